// File: dv/gpt_rtc_src.sv
/*
 * Model of the slow external clock feeding capture pin 0.
 * Assumes the bench gates it; it rests low while stopped.
 */
`timescale 1ns/1ps
module gpt_rtc_src #(
	parameter int HALF_NS = 15259
) (
	// control
	input wire logic run,
	// clock out
	output logic extClk
);
	// 32.768 kHz square wave, still outside use
	initial begin
		extClk = 1'b0;
		forever begin
			#(HALF_NS);
			extClk = run ? ~extClk : 1'b0;
		end
	end
endmodule // gpt_rtc_src

// File: dv/gpt_timer_sva.sv
/*
 * Port checker for the timer block, bound to its top module.
 * Assumes one-cycle bus strobes and reset low from time zero.
 */
`timescale 1ns/1ps
module gpt_timer_sva (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [gpt_pkg::ADDR_W-1:0] regAddr,
	input wire logic [gpt_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [gpt_pkg::DATA_W-1:0] regRdata_q,
	// events
	input wire logic intReq_q,
	input wire logic adcTrigger_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic noWr_q;
	logic trig_q;
	logic [31:0] mask_q;
	logic [2:0] clr_q;
	// coarse shadow of software writes, enough to bound the outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			noWr_q <= 1'b1;
			trig_q <= 1'b0;
			mask_q <= '0;
			clr_q <= '0;
		end else begin
			if (regWr) noWr_q <= 1'b0;
			if (regWr && regAddr == gpt_pkg::OFS_CONTROL) trig_q <= regWdata[gpt_pkg::CTL_TRIG_A];
			if (regWr && regAddr == gpt_pkg::OFS_INT_MASK) mask_q <= regWdata;
			clr_q <= {clr_q[1:0], regWr && (regAddr == gpt_pkg::OFS_INT_CLEAR
				|| regAddr == gpt_pkg::OFS_INT_MASK)};
		end
	end
	quiet_reset_a: assert property ($rose(rst_n) |-> !intReq_q && !adcTrigger_q)
		else $error("output active after reset");
	reset_halves_a: assert property ($past(regRd && noWr_q && (regAddr ==
		gpt_pkg::OFS_LOAD_B || regAddr == gpt_pkg::OFS_COUNT_B)) |-> regRdata_q == 32'h0000FFFF)
		else $error("half not all ones after reset");
	reset_prescale_a: assert property ($past(regRd && noWr_q && (regAddr ==
		gpt_pkg::OFS_PRESCALE_A || regAddr == gpt_pkg::OFS_PRESCALE_B)) |-> regRdata_q == '0)
		else $error("prescale not zero after reset");
	reset_ctl_a: assert property ($past(regRd && noWr_q && (regAddr ==
		gpt_pkg::OFS_CONFIG || regAddr == gpt_pkg::OFS_CONTROL)) |-> regRdata_q == '0)
		else $error("control not cleared after reset");
	read_idle_a: assert property (!$past(regRd) |-> regRdata_q == '0)
		else $error("read data outside read slot");
	trig_gate_a: assert property (adcTrigger_q |-> trig_q || $past(trig_q))
		else $error("trigger without enable");
	int_mask_a: assert property (intReq_q |-> |{mask_q[0], mask_q[3],
		$past(mask_q[0]), $past(mask_q[3])})
		else $error("interrupt while masked");
	flag_sticky_a: assert property ($fell(intReq_q) |-> clr_q != 3'h0)
		else $error("flag dropped without clear");
endmodule // gpt_timer_sva

// File: dv/gpt_timer_test.sv
/*
 * Self-checking bench for the timer block: bus tasks and scenarios.
 * Assumes the package is compiled first; divider shortened to 4 edges.
 */
`timescale 1ns/1ps
module gpt_timer_test;
	logic clk, rst_n, regWr, regRd, debugHalt, capturePin0, intReq_q, adcTrigger_q, srcRun;
	logic [7:0] regAddr;
	logic [31:0] regWdata, regRdata_q;
	int cycles, mismatches, nCompared, n;
	// system clock, 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	gpt_timer #(.RTC_EDGES(4)) i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
		.debugHalt(debugHalt), .capturePin0(capturePin0), .intReq_q(intReq_q),
		.adcTrigger_q(adcTrigger_q));
	gpt_rtc_src i_src (.run(srcRun), .extClk(capturePin0));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		nCompared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 check($sformatf("reg %h", a), exp, regRdata_q);
	endtask
	// bounded wait on trigger (sel=1) or interrupt
	task automatic waitEv(input bit sel, input int limit);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (!((sel ? adcTrigger_q : intReq_q) === 1'b1) && n < limit);
	endtask
	task automatic testReset;
		rd(gpt_pkg::OFS_LOAD_A, 32'hFFFFFFFF);
		rd(gpt_pkg::OFS_LOAD_B, 32'h0000FFFF);
		rd(gpt_pkg::OFS_COUNT_A, 32'hFFFFFFFF);
		rd(gpt_pkg::OFS_COUNT_B, 32'h0000FFFF);
		rd(gpt_pkg::OFS_PRESCALE_A, 32'h0);
		rd(gpt_pkg::OFS_PRESCALE_B, 32'h0);
		rd(gpt_pkg::OFS_CONTROL, 32'h0);
		rd(gpt_pkg::OFS_CONFIG, 32'h0);
		rd(8'hF0, 32'h0);
	endtask
	task automatic testOneShot;
		wr(gpt_pkg::OFS_LOAD_A, 32'hABCD1234);
		rd(gpt_pkg::OFS_LOAD_B, 32'h0000ABCD);
		wr(gpt_pkg::OFS_LOAD_A, 32'h3);
		wr(gpt_pkg::OFS_MODE_A, 32'(gpt_pkg::MODE_ONE_SHOT));
		wr(gpt_pkg::OFS_INT_MASK, 32'h1);
		wr(gpt_pkg::OFS_CONTROL, 32'h21);
		waitEv(1'b1, 20);
		check("period", 32'h4, 32'(n));
		check("int", 32'h1, 32'(intReq_q));
		rd(gpt_pkg::OFS_CONTROL, 32'h20);
		rd(gpt_pkg::OFS_MASK_STAT, 32'h1);
		rd(gpt_pkg::OFS_COUNT_A, 32'h3);
		wr(gpt_pkg::OFS_INT_CLEAR, 32'h1);
		rd(gpt_pkg::OFS_RAW_STAT, 32'h0);
	endtask
	task automatic testPeriodic;
		wr(gpt_pkg::OFS_INT_MASK, 32'h0);
		wr(gpt_pkg::OFS_MODE_A, 32'(gpt_pkg::MODE_PERIODIC));
		wr(gpt_pkg::OFS_CONTROL, 32'h1);
		waitEv(1'b1, 12);
		check("trigger", 32'h0, 32'(adcTrigger_q));
		rd(gpt_pkg::OFS_CONTROL, 32'h1);
		rd(gpt_pkg::OFS_RAW_STAT, 32'h1);
		rd(gpt_pkg::OFS_MASK_STAT, 32'h0);
		wr(gpt_pkg::OFS_LOAD_A, 32'd100);
		rd(gpt_pkg::OFS_COUNT_A, 32'd99);
		@(posedge clk);
		debugHalt <= 1'b1;
		wr(gpt_pkg::OFS_CONTROL, 32'h3);
		wr(gpt_pkg::OFS_LOAD_A, 32'd50);
		repeat (5) @(posedge clk);
		rd(gpt_pkg::OFS_COUNT_A, 32'd50);
		@(posedge clk);
		debugHalt <= 1'b0;
		rd(gpt_pkg::OFS_COUNT_A, 32'd49);
		wr(gpt_pkg::OFS_CONTROL, 32'h0);
		wr(gpt_pkg::OFS_INT_CLEAR, 32'h1);
	endtask
	// halt held high: stall bits must not freeze the clock count
	task automatic testRtc;
		@(posedge clk);
		debugHalt <= 1'b1;
		wr(gpt_pkg::OFS_CONFIG, 32'(gpt_pkg::CFG_32_RTC));
		rd(gpt_pkg::OFS_COUNT_A, 32'h1);
		wr(gpt_pkg::OFS_MATCH_A, 32'h2);
		wr(gpt_pkg::OFS_INT_MASK, 32'h8);
		wr(gpt_pkg::OFS_CONTROL, 32'h213);
		srcRun = 1'b1;
		waitEv(1'b0, 4000);
		check("rtc int", 32'h1, 32'(intReq_q));
		// two ticks of 4 source edges each, plus up to one source half period of phase
		check("rtc delay", 32'h1, 32'(n > 2130 && n < 2300));
		rd(gpt_pkg::OFS_COUNT_A, 32'h0);
		rd(gpt_pkg::OFS_RAW_STAT, 32'h8);
		wr(gpt_pkg::OFS_INT_CLEAR, 32'h8);
		rd(gpt_pkg::OFS_MASK_STAT, 32'h0);
	endtask
	task automatic endOfTest;
		$display("compared %0d mismatches %0d", nCompared, mismatches);
		if (mismatches == 0 && nCompared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 9000) begin
			mismatches++;
			endOfTest();
		end
	end
	initial begin
		{regAddr, regWdata, regWr, regRd, debugHalt, srcRun, rst_n} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		testReset();
		testOneShot();
		testPeriodic();
		testRtc();
		endOfTest();
	end
endmodule // gpt_timer_test
bind gpt_timer gpt_timer_sva i_sva (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
	.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
	.intReq_q(intReq_q), .adcTrigger_q(adcTrigger_q));

// File: include/gpt_pkg.sv
/*
 * Shared constants and types for the general-purpose timer block:
 * register offsets, field positions, reset values, mode codes.
 * Assumes a plain synchronous register port with byte addresses.
 */
package gpt_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int PRE_W = 8;

	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_MODE_A = 8'h04;
	localparam logic [7:0] OFS_MODE_B = 8'h08;
	localparam logic [7:0] OFS_CONTROL = 8'h0C;
	localparam logic [7:0] OFS_INT_MASK = 8'h18;
	localparam logic [7:0] OFS_RAW_STAT = 8'h1C;
	localparam logic [7:0] OFS_MASK_STAT = 8'h20;
	localparam logic [7:0] OFS_INT_CLEAR = 8'h24;
	localparam logic [7:0] OFS_LOAD_A = 8'h28;
	localparam logic [7:0] OFS_LOAD_B = 8'h2C;
	localparam logic [7:0] OFS_MATCH_A = 8'h30;
	localparam logic [7:0] OFS_MATCH_B = 8'h34;
	localparam logic [7:0] OFS_PRESCALE_A = 8'h38;
	localparam logic [7:0] OFS_PRESCALE_B = 8'h3C;
	localparam logic [7:0] OFS_COUNT_A = 8'h48;
	localparam logic [7:0] OFS_COUNT_B = 8'h4C;

	// configuration codes
	localparam logic [2:0] CFG_32_PERIODIC = 3'h0;
	localparam logic [2:0] CFG_32_RTC = 3'h1;
	localparam logic [2:0] CFG_16_SPLIT = 3'h4;

	// half mode field codes
	localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;

	// control register bit positions
	localparam int CTL_EN_A = 0;
	localparam int CTL_STALL_A = 1;
	localparam int CTL_RTC_EN = 4;
	localparam int CTL_TRIG_A = 5;
	localparam int CTL_STALL_B = 9;

	// status bit positions (raw, masked, mask and clear share them)
	localparam int ST_TIMEOUT_A = 0;
	localparam int ST_RTC = 3;

	// reset values, plus the count loaded when RTC is first selected
	localparam logic [15:0] RST_HALF = 16'hFFFF;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [31:0] RTC_FIRST_LOAD = 32'h00000001;
	localparam logic [15:0] RST_MATCH = 16'hFFFF;
	localparam logic [2:0] RST_CONFIG = 3'h0;
	localparam logic [1:0] RST_MODE = 2'h0;
	localparam logic [3:0] RST_MASK = 4'h0;

	// external clock edges per one-second tick
	localparam int RTC_DIV_EDGES = 32768;

	// control register as a carrier of its fields
	typedef struct packed {
		logic stallB;
		logic trigA;
		logic rtc_enable_bit;
		logic stallA;
		logic enA;
	} gpt_ctl_t;

endpackage

// File: rtl/gpt_rtc_div.sv
/*
 * Divider for the real-time-clock input: brings the slow external
 * clock into the system domain and gives one enable pulse per
 * programmed number of its rising edges.
 * Assumes the system clock is far faster than the external clock.
 */
`timescale 1ns/1ps
module gpt_rtc_div #(
	parameter int EDGES = gpt_pkg::RTC_DIV_EDGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control and external clock
	input wire logic run,
	input wire logic extClk,
	// one-cycle tick
	output logic tick_q
);
	localparam int CW = $clog2(EDGES);
	localparam logic [CW-1:0] LAST = CW'(EDGES - 1);

	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic [CW-1:0] edgeCnt_q;
	logic rise;

	// two-flop synchroniser plus one stage for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= extClk;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	assign rise = sync2_q & ~sync3_q;

	// edge counter, cleared while not running so each start is a full second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edgeCnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (!run) begin
				edgeCnt_q <= '0;
			end else if (rise) begin
				if (edgeCnt_q == LAST) begin
					edgeCnt_q <= '0;
					tick_q <= 1'b1;
				end else begin
					edgeCnt_q <= edgeCnt_q + 1'b1;
				end
			end
		end
	end

endmodule // gpt_rtc_div

// File: rtl/gpt_timer.sv
/*
 * General-purpose timer block: two 16-bit halves with load, match and
 * prescale registers, joined into a 32-bit one-shot/periodic
 * down-counter or a 32-bit real-time-clock up-counter.
 * The split 16-bit modes are not built: under any other configuration
 * code the halves hold still, and the prescalers are stored only.
 * Assumes a synchronous register port, a debug-halt level from the
 * processor, and a slow external clock on capture pin 0.
 */
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// Function
// - two 16-bit halves with load, match, prescale
// - counters and loads reset to all ones
// - prescale registers reset to zero
// - reset leaves block idle, controls cleared
// - config 0 one-shot/periodic, 1 RTC
// - 32-bit modes act as one timer
// - 32-bit load write splits into halves
// - 32-bit count read joins both halves
// - half A mode alone picks one-shot/periodic
// - count down, reload at zero next cycle
// - one-shot stops and clears enable; periodic continues
// - zero sets sticky time-out flag until cleared
// - unmasked time-out shows in masked status
// - ADC trigger only when trigger enable set
// - load write while running takes effect next cycle
// - stall bit freezes counter in debug halt
// - RTC counts up, first selection loads one
// - external 32.768 kHz divided to 1 Hz
// - RTC match rolls over to zero, continues
// - RTC match sets raw, masked flag, interrupt
// - RTC enable overrides debug stall
module gpt_timer #(
	parameter int RTC_EDGES = gpt_pkg::RTC_DIV_EDGES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [gpt_pkg::ADDR_W-1:0] regAddr,
	input wire logic [gpt_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [gpt_pkg::DATA_W-1:0] regRdata_q,
	// system
	input wire logic debugHalt,
	input wire logic capturePin0,
	// events
	output logic intReq_q,
	output logic adcTrigger_q
);

	logic [2:0] timerConfig_q;
	logic [1:0] modeA_q;
	logic [1:0] modeB_q;
	gpt_pkg::gpt_ctl_t ctl_q;
	logic [3:0] intMask_q;
	logic [3:0] rawStat_q;
	logic [15:0] loadA_q;
	logic [15:0] loadB_q;
	logic [15:0] matchA_q;
	logic [15:0] matchB_q;
	logic [7:0] preA_q;
	logic [7:0] preB_q;
	logic [15:0] cntA_q;
	logic [15:0] cntB_q;
	logic rtcSeen_q;

	logic wrCfg;
	logic wrModeA;
	logic wrModeB;
	logic wrCtl;
	logic wrMask;
	logic wrClr;
	logic wrLoadA;
	logic wrLoadB;
	logic wrMatchA;
	logic wrMatchB;
	logic wrPreA;
	logic wrPreB;
	logic mode32;
	logic modeRtc;
	logic modeDown;
	logic stallNow;
	logic rtcTick;
	logic [31:0] cnt32;
	logic [31:0] load32;
	logic [31:0] match32;
	logic downZero;
	logic downRun;
	logic rtcRun;
	logic rtcMatch;
	logic timeoutEv;
	logic rtcEv;
	logic enAClear;
	logic [3:0] setBits;
	logic [3:0] rawNext;
	logic [31:0] rdMux;

	// one-cycle decode of a write strobe against an offset
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
		hit = s && (a == ofs);
	endfunction

	assign wrCfg = hit(regAddr, gpt_pkg::OFS_CONFIG, regWr);
	assign wrModeA = hit(regAddr, gpt_pkg::OFS_MODE_A, regWr);
	assign wrModeB = hit(regAddr, gpt_pkg::OFS_MODE_B, regWr);
	assign wrCtl = hit(regAddr, gpt_pkg::OFS_CONTROL, regWr);
	assign wrMask = hit(regAddr, gpt_pkg::OFS_INT_MASK, regWr);
	assign wrClr = hit(regAddr, gpt_pkg::OFS_INT_CLEAR, regWr);
	assign wrLoadA = hit(regAddr, gpt_pkg::OFS_LOAD_A, regWr);
	assign wrLoadB = hit(regAddr, gpt_pkg::OFS_LOAD_B, regWr);
	assign wrMatchA = hit(regAddr, gpt_pkg::OFS_MATCH_A, regWr);
	assign wrMatchB = hit(regAddr, gpt_pkg::OFS_MATCH_B, regWr);
	assign wrPreA = hit(regAddr, gpt_pkg::OFS_PRESCALE_A, regWr);
	assign wrPreB = hit(regAddr, gpt_pkg::OFS_PRESCALE_B, regWr);

	// mode decode; the split 16-bit modes are not built, halves idle there
	assign modeDown = (timerConfig_q == gpt_pkg::CFG_32_PERIODIC);
	assign modeRtc = (timerConfig_q == gpt_pkg::CFG_32_RTC);
	assign mode32 = modeDown | modeRtc;

	// debug stall, never in effect while the RTC enable is set
	assign stallNow = debugHalt & ctl_q.stallA & ~ctl_q.rtc_enable_bit;

	assign cnt32 = {cntB_q, cntA_q};
	assign load32 = {loadB_q, loadA_q};
	assign match32 = {matchB_q, matchA_q};

	// down-counter events
	assign downRun = modeDown & ctl_q.enA & ~stallNow;
	assign downZero = downRun & (cnt32 == 32'h00000000);
	assign timeoutEv = downZero;

	// rtc events; the stall bits freeze the clock only while the RTC
	// enable is clear, so a debugger halt cannot lose wall-clock seconds
	assign rtcRun = modeRtc & ctl_q.enA & ~(debugHalt & (ctl_q.stallA | ctl_q.stallB) & ~ctl_q.rtc_enable_bit);
	assign rtcMatch = rtcRun & rtcTick & (cnt32 == match32);
	assign rtcEv = rtcMatch;

	// one-shot clears its own enable on the reload cycle
	assign enAClear = downZero & (modeA_q == gpt_pkg::MODE_ONE_SHOT);

	gpt_rtc_div #(
		.EDGES(RTC_EDGES)
	) u_rtc_div (
		.clk(clk),
		.rst_n(rst_n),
		.run(rtcRun),
		.extClk(capturePin0),
		.tick_q(rtcTick)
	);

	// configuration register; only codes 0 and 1 make the halves count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timerConfig_q <= gpt_pkg::RST_CONFIG;
		end else if (wrCfg) begin
			timerConfig_q <= regWdata[2:0];
		end
	end

	// half A mode field; in the 32-bit modes it alone picks the mode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeA_q <= gpt_pkg::RST_MODE;
		end else if (wrModeA) begin
			modeA_q <= regWdata[1:0];
		end
	end

	// half B mode field, kept for read-back only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modeB_q <= gpt_pkg::RST_MODE;
		end else if (wrModeB) begin
			modeB_q <= regWdata[1:0];
		end
	end

	// interrupt mask, one bit per status flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intMask_q <= gpt_pkg::RST_MASK;
		end else if (wrMask) begin
			intMask_q <= regWdata[3:0];
		end
	end

	// control register; a software write in the same cycle beats the self-clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= '0;
		end else if (wrCtl) begin
			ctl_q.enA <= regWdata[gpt_pkg::CTL_EN_A];
			ctl_q.stallA <= regWdata[gpt_pkg::CTL_STALL_A];
			ctl_q.rtc_enable_bit <= regWdata[gpt_pkg::CTL_RTC_EN];
			ctl_q.trigA <= regWdata[gpt_pkg::CTL_TRIG_A];
			ctl_q.stallB <= regWdata[gpt_pkg::CTL_STALL_B];
		end else if (enAClear) begin
			ctl_q.enA <= 1'b0;
		end
	end

	// load registers; in 32-bit modes one word fills both halves
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			loadA_q <= gpt_pkg::RST_HALF;
			loadB_q <= gpt_pkg::RST_HALF;
		end else if (wrLoadA) begin
			loadA_q <= regWdata[15:0];
			if (mode32) begin
				loadB_q <= regWdata[31:16];
			end
		end else if (wrLoadB) begin
			loadB_q <= regWdata[15:0];
		end
	end

	// match registers; the RTC takes its later targets through half A
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			matchA_q <= gpt_pkg::RST_MATCH;
			matchB_q <= gpt_pkg::RST_MATCH;
		end else if (wrMatchA) begin
			matchA_q <= regWdata[15:0];
			if (mode32) begin
				matchB_q <= regWdata[31:16];
			end
		end else if (wrMatchB) begin
			matchB_q <= regWdata[15:0];
		end
	end

	// prescale registers, stored only: the 32-bit modes never prescale
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			preA_q <= gpt_pkg::RST_PRESCALE;
			preB_q <= gpt_pkg::RST_PRESCALE;
		end else begin
			if (wrPreA) begin
				preA_q <= regWdata[7:0];
			end
			if (wrPreB) begin
				preB_q <= regWdata[7:0];
			end
		end
	end

	// remembers that the RTC mode has been selected once since reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rtcSeen_q <= 1'b0;
		end else if (wrCfg && regWdata[2:0] == gpt_pkg::CFG_32_RTC) begin
			rtcSeen_q <= 1'b1;
		end
	end

	// the 32-bit counter, held as two halves; a load write beats the
	// reload so that the new value lands on the very next cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cntA_q <= gpt_pkg::RST_HALF;
			cntB_q <= gpt_pkg::RST_HALF;
		end else if (wrCfg && regWdata[2:0] == gpt_pkg::CFG_32_RTC && !rtcSeen_q) begin
			cntA_q <= gpt_pkg::RTC_FIRST_LOAD[15:0];
			cntB_q <= gpt_pkg::RTC_FIRST_LOAD[31:16];
		end else if (modeDown && wrLoadA) begin
			cntA_q <= regWdata[15:0];
			cntB_q <= regWdata[31:16];
		end else if (downZero) begin
			cntA_q <= load32[15:0];
			cntB_q <= load32[31:16];
		end else if (downRun) begin
			{cntB_q, cntA_q} <= cnt32 - 32'h00000001;
		end else if (rtcMatch) begin
			cntA_q <= 16'h0000;
			cntB_q <= 16'h0000;
		end else if (rtcRun && rtcTick) begin
			{cntB_q, cntA_q} <= cnt32 + 32'h00000001;
		end
	end

	// sticky raw status; a new event wins over a clear in the same cycle
	assign setBits = {rtcEv, 2'b00, timeoutEv};
	assign rawNext = (rawStat_q & ~(wrClr ? regWdata[3:0] : 4'h0)) | setBits;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rawStat_q <= 4'h0;
		end else begin
			rawStat_q <= rawNext;
		end
	end

	// interrupt and ADC trigger outputs, both from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intReq_q <= 1'b0;
			adcTrigger_q <= 1'b0;
		end else begin
			intReq_q <= |(rawNext & intMask_q);
			adcTrigger_q <= timeoutEv & ctl_q.trigA;
		end
	end

	// read mux; unmapped offsets read as zero, and the half A load, match and count offsets
	// show the joined 32-bit word while a 32-bit mode is selected
	always_comb begin
		rdMux = 32'h00000000;
		unique case (regAddr)
			gpt_pkg::OFS_CONFIG: rdMux = {29'h0, timerConfig_q};
			gpt_pkg::OFS_MODE_A: rdMux = {30'h0, modeA_q};
			gpt_pkg::OFS_MODE_B: rdMux = {30'h0, modeB_q};
			gpt_pkg::OFS_CONTROL: rdMux = {22'h0, ctl_q.stallB, 3'h0, ctl_q.trigA,
				ctl_q.rtc_enable_bit, 2'h0, ctl_q.stallA, ctl_q.enA};
			gpt_pkg::OFS_INT_MASK: rdMux = {28'h0, intMask_q};
			gpt_pkg::OFS_RAW_STAT: rdMux = {28'h0, rawStat_q};
			gpt_pkg::OFS_MASK_STAT: rdMux = {28'h0, rawStat_q & intMask_q};
			gpt_pkg::OFS_LOAD_A: rdMux = mode32 ? load32 : {16'h0, loadA_q};
			gpt_pkg::OFS_LOAD_B: rdMux = {16'h0, loadB_q};
			gpt_pkg::OFS_MATCH_A: rdMux = mode32 ? match32 : {16'h0, matchA_q};
			gpt_pkg::OFS_MATCH_B: rdMux = {16'h0, matchB_q};
			gpt_pkg::OFS_PRESCALE_A: rdMux = {24'h0, preA_q};
			gpt_pkg::OFS_PRESCALE_B: rdMux = {24'h0, preB_q};
			gpt_pkg::OFS_COUNT_A: rdMux = mode32 ? cnt32 : {16'h0, cntA_q};
			gpt_pkg::OFS_COUNT_B: rdMux = {16'h0, cntB_q};
			default: rdMux = 32'h00000000;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata_q <= 32'h00000000;
		end else begin
			regRdata_q <= regRd ? rdMux : 32'h00000000;
		end
	end

endmodule // gpt_timer
